// ==== common/idmd_cfg.svh ====
// Address map, field positions and reset values of the internal data memory decoder
`ifndef IDMD_CFG_SVH
`define IDMD_CFG_SVH

// ==========================================================
// Address map
`define IDMD_RAM_BYTES       256
`define IDMD_DIRECT_TOP      8'h7f
`define IDMD_BANK_TOP        8'h1f
`define IDMD_BIT_BYTE_BASE   8'h20
`define IDMD_BIT_BYTE_TOP    8'h2f
`define IDMD_BIT_ADDR_TOP    8'h7f
`define IDMD_SP_ADDR         8'h81
`define IDMD_PSW_ADDR        8'hd0
`define IDMD_EMI_ADDR        8'he7

// ==========================================================
// Fields and reset values
`define IDMD_PSW_BANK_LSB    3
`define IDMD_SP_RESET        8'h07
`define IDMD_PSW_RESET       8'h00
`define IDMD_EMI_RESET       8'h00

`endif

// ==== common/idmd_pkg.sv ====
// Types shared by the internal data memory decoder and its users
package idmd_pkg;

	// ======================================================
	// Access kinds chosen by the instruction operand type
	typedef enum logic [2:0] {
		IDMD_DIRECT   = 3'h0,
		IDMD_INDIRECT = 3'h1,
		IDMD_REGISTER = 3'h2,
		IDMD_BIT      = 3'h3,
		IDMD_PUSH     = 3'h4,
		IDMD_POP      = 3'h5
	} idmd_mode_t;

	typedef enum logic [1:0] {
		IDMD_IDLE = 2'b00,
		IDMD_PTR  = 2'b01,
		IDMD_DATA = 2'b11
	} idmd_state_t;

	// ======================================================
	// Request, answer and forwarded special function access
	typedef struct packed {
		logic       valid;
		idmd_mode_t mode;
		logic [7:0] addr;
		logic       sel;
		logic       we;
		logic [7:0] wdata;
		logic       wbit;
	} idmd_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] rdata;
		logic       rbit;
	} idmd_rsp_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic       we;
		logic [7:0] wdata;
		logic       is_bit;
		logic [2:0] bitpos;
		logic       wbit;
	} idmd_sfr_t;

endpackage : idmd_pkg

// ==== hdl/idmd_ram.sv ====
// Byte-wide single-port RAM with registered read data and no reset on contents
`timescale 1ns/10ps
`default_nettype none

module idmd_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 256,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clk_i,
	input  wire logic             en_i,
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    addr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	output var  logic [WIDTH-1:0] rdata_o
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Contents survive every reset, so no reset term here
	always_ff @(posedge clk_i) begin
		if (en_i) begin
			if (we_i) begin
				mem[addr_i] <= wdata_i;
			end
			rdata_o <= mem[addr_i];
		end
	end

endmodule : idmd_ram

`default_nettype wire

// ==== hdl/idmd_bitmap.sv ====
// Maps a bit address onto its byte address and bit position
`timescale 1ns/10ps
`default_nettype none

`include "idmd_cfg.svh"

module idmd_bitmap (
	input  wire logic [7:0] bit_addr_i,
	output var  logic [7:0] byte_addr_o,
	output var  logic [2:0] bitpos_o,
	output var  logic       in_ram_o
);

	always_comb begin
		bitpos_o = bit_addr_i[2:0];
		in_ram_o = (bit_addr_i <= `IDMD_BIT_ADDR_TOP);
		if (in_ram_o) begin
			byte_addr_o = `IDMD_BIT_BYTE_BASE | {4'h0, bit_addr_i[6:3]};
		end else begin
			byte_addr_o = {bit_addr_i[7:3], 3'b000};
		end
	end

endmodule : idmd_bitmap

`default_nettype wire

// ==== hdl/idmd_top.sv ====
// Internal data memory decoder: RAM, register banks, bit area and stack pointer
`timescale 1ns/10ps
`default_nettype none

`include "idmd_cfg.svh"

// Summary of operation
// - 256 bytes of internal RAM span addresses 0x00 to 0xFF.
// - Lower 128 bytes reachable by direct and indirect accesses.
// - Upper 128 bytes reachable only indirectly, separate from special function space.
// - Direct access above 0x7F goes to special function space.
// - Indirect access above 0x7F goes to upper RAM.
// - Bytes 0x00..0x1F form four banks of eight working registers.
// - One bank active, selected by two bits of the status word.
// - Indirect pointer comes from register zero or one of active bank.
// - Bytes 0x20..0x2F also form 128 bits, addresses 0x00..0x7F.
// - Bit address n is bit n%8 of byte 0x20+n/8.
// - Bit or byte access follows operand type, not address.
// - Stack pointer names last used slot; push writes at pointer plus one.
// - Reset sets stack pointer to 0x07; first push lands at 0x08.
// - Stack may sit anywhere in the 256 bytes, wrapping around.
// - Reset leaves RAM contents untouched.
// - RAM beyond 256 bytes lives in external space, not decoded here.
// - No instruction fetch from data memory; data storage only.
module idmd_top #(
	parameter int RAM_DEPTH = `IDMD_RAM_BYTES
) (
	input  wire logic               clk_i,
	input  wire logic               rst_b_i,
	input  wire idmd_pkg::idmd_req_t req_i,
	output var  logic               req_ready_o,
	output var  idmd_pkg::idmd_rsp_t rsp_o,
	output var  idmd_pkg::idmd_sfr_t sfr_o,
	output var  logic [7:0]         stack_pointer_o,
	output var  logic [7:0]         program_status_word_o,
	output var  logic [7:0]         external_memory_interface_control_o
);
	import idmd_pkg::*;

	// ======================================================
	// State
	typedef struct packed {
		idmd_state_t state;
		logic        ready;
		idmd_req_t   req;
		logic [7:0]  tgt;
		logic [2:0]  bitpos;
		logic [7:0]  sp;
		logic [7:0]  program_status_word;
		logic [7:0]  emi;
		idmd_rsp_t   rsp;
		idmd_sfr_t   special_function_space;
	} idmd_regs_t;

	idmd_regs_t st_ff;
	idmd_regs_t nxt_st;

	logic       ram_en;
	logic       ram_we;
	logic [7:0] ram_addr;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;
	logic [7:0] bm_byte;
	logic [2:0] bm_pos;
	logic       bm_in_ram;

	// ======================================================
	// Storage and bit mapping
	// Only data ports exist; there is no fetch path into this RAM.
	idmd_ram #(
		.WIDTH (8),
		.DEPTH (RAM_DEPTH)
	) u_ram (
		.clk_i   (clk_i),
		.en_i    (ram_en),
		.we_i    (ram_we),
		.addr_i  (ram_addr),
		.wdata_i (ram_wdata),
		.rdata_o (ram_rdata)
	);

	idmd_bitmap u_bitmap (
		.bit_addr_i  (req_i.addr),
		.byte_addr_o (bm_byte),
		.bitpos_o    (bm_pos),
		.in_ram_o    (bm_in_ram)
	);

	// ======================================================
	// Decode and sequencing
	always_comb begin
		logic [1:0] bank;
		logic       go_ram;
		logic [7:0] op_addr;
		logic       is_local;
		logic [7:0] loc_addr;
		logic [7:0] loc_val;
		logic [7:0] loc_new;
		idmd_req_t  rq;

		nxt_st    = st_ff;
		bank      = st_ff.program_status_word[`IDMD_PSW_BANK_LSB +: 2];
		go_ram    = 1'b0;
		op_addr   = 8'h00;
		is_local  = 1'b0;
		loc_addr  = 8'h00;
		loc_val   = 8'h00;
		loc_new   = 8'h00;
		rq        = st_ff.req;
		ram_en    = 1'b0;
		ram_we    = 1'b0;
		ram_addr  = st_ff.tgt;
		ram_wdata = st_ff.req.wdata;
		nxt_st.rsp.valid = 1'b0;
		nxt_st.special_function_space.valid = 1'b0;

		unique case (st_ff.state)
			IDMD_IDLE: begin
				if (req_i.valid) begin
					rq          = req_i;
					nxt_st.req  = req_i;
					nxt_st.bitpos = 3'h0;
					unique case (req_i.mode)
						IDMD_DIRECT: begin
							if (req_i.addr > `IDMD_DIRECT_TOP) begin
								is_local = 1'b1;
								loc_addr = req_i.addr;
							end else begin
								go_ram  = 1'b1;
								op_addr = req_i.addr;
							end
						end
						IDMD_INDIRECT: begin
							// Pointer read first, target on the next cycle
							ram_en   = 1'b1;
							ram_addr = {3'b000, bank, 2'b00, req_i.sel};
							nxt_st.state = IDMD_PTR;
						end
						IDMD_REGISTER: begin
							go_ram  = 1'b1;
							op_addr = {3'b000, bank, req_i.addr[2:0]};
						end
						IDMD_BIT: begin
							nxt_st.bitpos = bm_pos;
							if (bm_in_ram) begin
								go_ram  = 1'b1;
								op_addr = bm_byte;
							end else begin
								is_local = 1'b1;
								loc_addr = bm_byte;
							end
						end
						IDMD_PUSH: begin
							go_ram    = 1'b1;
							op_addr   = st_ff.sp + 8'h01;
							nxt_st.sp = st_ff.sp + 8'h01;
						end
						IDMD_POP: begin
							go_ram    = 1'b1;
							op_addr   = st_ff.sp;
							nxt_st.sp = st_ff.sp - 8'h01;
						end
						default: begin
							// Unused mode codes answer with zero
							nxt_st.rsp = '{valid: 1'b1, rdata: 8'h00, rbit: 1'b0};
						end
					endcase
				end
			end
			IDMD_PTR: begin
				// Indirect target uses full 8 bits and never reaches the SPECIAL_FUNCTION_SPACE side
				go_ram  = 1'b1;
				op_addr = ram_rdata;
			end
			IDMD_DATA: begin
				nxt_st.state = IDMD_IDLE;
				if (st_ff.req.mode == IDMD_BIT && st_ff.req.we) begin
					// Read-modify-write keeps the other seven bits
					ram_en    = 1'b1;
					ram_we    = 1'b1;
					ram_addr  = st_ff.tgt;
					ram_wdata = ram_rdata;
					ram_wdata[st_ff.bitpos] = st_ff.req.wbit;
					nxt_st.rsp = '{valid: 1'b1, rdata: ram_wdata, rbit: st_ff.req.wbit};
				end else begin
					nxt_st.rsp = '{valid: 1'b1, rdata: ram_rdata, rbit: ram_rdata[st_ff.bitpos]};
				end
			end
			default: begin
				nxt_st.state = IDMD_IDLE;
			end
		endcase

		// Common RAM issue; byte writes finish at once, reads and bit writes wait a cycle
		if (go_ram) begin
			ram_en     = 1'b1;
			ram_addr   = op_addr;
			ram_we     = (rq.we || rq.mode == IDMD_PUSH) && rq.mode != IDMD_BIT && rq.mode != IDMD_POP;
			ram_wdata  = rq.wdata;
			nxt_st.tgt = op_addr;
			if (ram_we) begin
				nxt_st.state = IDMD_IDLE;
				nxt_st.rsp   = '{valid: 1'b1, rdata: rq.wdata, rbit: 1'b0};
			end else begin
				nxt_st.state = IDMD_DATA;
			end
		end

		// Registers held here answer locally; all other SPECIAL_FUNCTION_SPACE traffic is forwarded
		if (is_local) begin
			nxt_st.state = IDMD_IDLE;
			unique case (loc_addr)
				`IDMD_SP_ADDR:  loc_val = st_ff.sp;
				`IDMD_PSW_ADDR: loc_val = st_ff.program_status_word;
				`IDMD_EMI_ADDR: loc_val = st_ff.emi;
				default:        loc_val = 8'h00;
			endcase
			loc_new = rq.wdata;
			if (rq.mode == IDMD_BIT) begin
				loc_new = loc_val;
				loc_new[bm_pos] = rq.wbit;
			end
			if (loc_addr == `IDMD_SP_ADDR || loc_addr == `IDMD_PSW_ADDR || loc_addr == `IDMD_EMI_ADDR) begin
				if (rq.we) begin
					unique case (loc_addr)
						`IDMD_SP_ADDR:  nxt_st.sp  = loc_new;
						`IDMD_PSW_ADDR: nxt_st.program_status_word = loc_new;
						default:        nxt_st.emi = loc_new;
					endcase
				end
				nxt_st.rsp = '{valid: 1'b1, rdata: rq.we ? loc_new : loc_val,
					rbit: rq.we ? rq.wbit : loc_val[bm_pos]};
			end else begin
				nxt_st.special_function_space = '{valid: 1'b1, addr: loc_addr, we: rq.we, wdata: rq.wdata,
					is_bit: rq.mode == IDMD_BIT, bitpos: bm_pos, wbit: rq.wbit};
			end
		end

		nxt_st.ready = (nxt_st.state == IDMD_IDLE);
	end

	// ======================================================
	// Registers; RAM itself is not reset
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_ff       <= '0;
			st_ff.ready <= 1'b1;
			st_ff.sp    <= `IDMD_SP_RESET;
			st_ff.program_status_word   <= `IDMD_PSW_RESET;
			st_ff.emi   <= `IDMD_EMI_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ======================================================
	// Outputs
	// Larger on-chip RAM belongs to the external space behind this control byte.
	assign req_ready_o                         = st_ff.ready;
	assign rsp_o                               = st_ff.rsp;
	assign sfr_o                               = st_ff.special_function_space;
	assign stack_pointer_o                     = st_ff.sp;
	assign program_status_word_o               = st_ff.program_status_word;
	assign external_memory_interface_control_o = st_ff.emi;

endmodule : idmd_top

`default_nettype wire

// ==== verif/idmd_checker.sv ====
// Port assertions for the internal data memory decoder
`timescale 1ns/10ps
`default_nettype none

module idmd_checker
	import idmd_pkg::*;
#(
	parameter int RAM_DEPTH = 256
) (
	input wire logic                clk_i,
	input wire logic                rst_b_i,
	input wire idmd_pkg::idmd_req_t req_i,
	input wire logic                req_ready_o,
	input wire idmd_pkg::idmd_rsp_t rsp_o,
	input wire idmd_pkg::idmd_sfr_t sfr_o,
	input wire logic [7:0]          stack_pointer_o,
	input wire logic [7:0]          program_status_word_o,
	input wire logic [7:0]          external_memory_interface_control_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// ==========================================================
	// Helpers
	logic tk;
	logic lcl;
	assign tk  = req_i.valid && req_ready_o;
	assign lcl = req_i.addr inside {8'h81, 8'hd0, 8'he7};

	sequence s_busy;
		!req_ready_o;
	endsequence
	sequence s_ans;
		rsp_o.valid && req_ready_o;
	endsequence

	// ==========================================================
	// Assertions
	AST_RESET_SP: assert property ($rose(rst_b_i) |-> stack_pointer_o == 8'h07)
		else $error("stack pointer wrong after reset");
	AST_PUSH_SP: assert property (tk && req_i.mode == IDMD_PUSH |=> rsp_o.valid &&
		stack_pointer_o == $past(stack_pointer_o) + 8'h01) else $error("push pointer step wrong");
	AST_POP_SP: assert property (tk && req_i.mode == IDMD_POP |=> ##1
		stack_pointer_o == $past(stack_pointer_o, 2) - 8'h01) else $error("pop pointer step wrong");
	AST_DIRECT_HIGH: assert property (tk && req_i.mode == IDMD_DIRECT && req_i.addr[7] && !lcl |=>
		sfr_o.valid && !rsp_o.valid && sfr_o.addr == $past(req_i.addr)) else $error("high direct not forwarded");
	AST_INDIRECT_RAM: assert property (tk && req_i.mode == IDMD_INDIRECT |=> !sfr_o.valid [*3])
		else $error("indirect access forwarded");
	AST_DIRECT_READ: assert property (tk && req_i.mode == IDMD_DIRECT && !req_i.addr[7] && !req_i.we
		|=> s_busy ##1 s_ans) else $error("direct read timing wrong");
	AST_INDIRECT_READ: assert property (tk && req_i.mode == IDMD_INDIRECT && !req_i.we
		|=> s_busy [*2] ##1 s_ans) else $error("indirect read timing wrong");
	AST_BIT_ACCESS: assert property (tk && req_i.mode == IDMD_BIT && !req_i.addr[7]
		|=> s_busy ##1 s_ans) else $error("bit access timing wrong");
endmodule : idmd_checker

bind idmd_top idmd_checker #(.RAM_DEPTH(RAM_DEPTH)) i_chk (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .req_ready_o(req_ready_o), .rsp_o(rsp_o), .sfr_o(sfr_o),
	.stack_pointer_o(stack_pointer_o), .program_status_word_o(program_status_word_o),
	.external_memory_interface_control_o(external_memory_interface_control_o));

`default_nettype wire

// ==== verif/idmd_core_model.sv ====
// Processor core model issuing byte and bit accesses
`timescale 1ns/10ps
`default_nettype none

module idmd_core_model
	import idmd_pkg::*;
(
	input  wire logic                clk_i,
	input  wire idmd_pkg::idmd_rsp_t rsp_i,
	input  wire idmd_pkg::idmd_sfr_t sfr_i,
	output var  idmd_pkg::idmd_req_t req_o
);
	logic [7:0] q;
	logic       qb;
	int         timeouts = 0;

	initial req_o = '0;

	// Entered just after a rising edge; the answer is sampled at falling edges
	task automatic access(input idmd_mode_t m, input logic [7:0] a, input logic s, input logic w,
		input logic [7:0] d, input logic b);
		int n;
		n = 0;
		req_o <= '{1'b1, m, a, s, w, d, b};
		@(posedge clk_i);
		req_o.valid <= 1'b0;
		do begin
			@(negedge clk_i);
			n++;
		end while (!(rsp_i.valid || sfr_i.valid) && n < 20);
		if (n == 20) timeouts++;
		q  = rsp_i.valid ? rsp_i.rdata : sfr_i.wdata;
		qb = rsp_i.rbit;
		@(posedge clk_i);
	endtask : access
endmodule : idmd_core_model

`default_nettype wire

// ==== verif/idmd_top_tb.sv ====
// Self-checking bench for the internal data memory decoder
`timescale 1ns/10ps
`default_nettype none

module idmd_top_tb;
	import idmd_pkg::*;

	logic       clk_i   = 1'b0;
	logic       rst_b_i = 1'b0;
	idmd_req_t  req;
	logic       ready;
	idmd_rsp_t  rsp;
	idmd_sfr_t  special_function_space;
	logic [7:0] sp;
	logic [7:0] program_status_word;
	logic [7:0] emi;
	int         errors    = 0;
	int         tests_run = 0;

	always #4 clk_i = ~clk_i;

	idmd_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .req_ready_o(ready), .rsp_o(rsp),
		.sfr_o(special_function_space), .stack_pointer_o(sp), .program_status_word_o(program_status_word),
		.external_memory_interface_control_o(emi));
	idmd_core_model i_core (.clk_i(clk_i), .rsp_i(rsp), .sfr_i(special_function_space), .req_o(req));

	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input idmd_mode_t m, input logic [7:0] a, input logic s, input logic [7:0] d, input logic b);
		i_core.access(m, a, s, 1'b1, d, b);
	endtask : wr

	task automatic rd(input idmd_mode_t m, input logic [7:0] a, input logic s, input logic [7:0] e);
		i_core.access(m, a, s, 1'b0, 8'h00, 1'b0);
		chk($sformatf("read %h", a), e, i_core.q);
	endtask : rd

	task automatic final_report;
		errors += i_core.timeouts;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	// ==========================================================
	// Sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		chk("sp", 8'h07, sp);
		chk("psw", 8'h00, program_status_word);
		chk("emi", 8'h00, emi);
		$display("test reset done");
		wr(IDMD_PUSH, 8'h00, 1'b0, 8'ha5, 1'b0);
		chk("sp", 8'h08, sp);
		rd(IDMD_DIRECT, 8'h08, 1'b0, 8'ha5);
		$display("test push done");
		wr(IDMD_DIRECT, 8'hd0, 1'b0, 8'h08, 1'b0);
		chk("psw", 8'h08, program_status_word);
		wr(IDMD_REGISTER, 8'h01, 1'b0, 8'h90, 1'b0);
		rd(IDMD_DIRECT, 8'h09, 1'b0, 8'h90);
		wr(IDMD_INDIRECT, 8'h00, 1'b1, 8'h3c, 1'b0);
		wr(IDMD_DIRECT, 8'h90, 1'b0, 8'h11, 1'b0);
		chk("fwd", 8'h11, i_core.q);
		rd(IDMD_INDIRECT, 8'h00, 1'b1, 8'h3c);
		$display("test banks done");
		wr(IDMD_DIRECT, 8'h22, 1'b0, 8'h00, 1'b0);
		wr(IDMD_BIT, 8'h13, 1'b0, 8'h00, 1'b1);
		rd(IDMD_DIRECT, 8'h22, 1'b0, 8'h08);
		wr(IDMD_DIRECT, 8'h2f, 1'b0, 8'h80, 1'b0);
		i_core.access(IDMD_BIT, 8'h7f, 1'b0, 1'b0, 8'h00, 1'b0);
		chk("bit 7f", 8'h01, {7'h00, i_core.qb});
		wr(IDMD_BIT, 8'hd4, 1'b0, 8'h00, 1'b1);
		chk("psw", 8'h18, program_status_word);
		wr(IDMD_DIRECT, 8'he7, 1'b0, 8'h3c, 1'b0);
		chk("emi", 8'h3c, emi);
		i_core.access(idmd_mode_t'(3'h6), 8'h22, 1'b0, 1'b0, 8'h00, 1'b0);
		chk("unused mode", 8'h00, i_core.q);
		$display("test bits done");
		wr(IDMD_DIRECT, 8'h81, 1'b0, 8'hff, 1'b0);
		wr(IDMD_PUSH, 8'h00, 1'b0, 8'h5a, 1'b0);
		chk("sp", 8'h00, sp);
		rd(IDMD_POP, 8'h00, 1'b0, 8'h5a);
		chk("sp", 8'hff, sp);
		$display("test wrap done");
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		chk("sp", 8'h07, sp);
		rd(IDMD_DIRECT, 8'h09, 1'b0, 8'h90);
		$display("test retain done");
		final_report;
	end
endmodule : idmd_top_tb

`default_nettype wire
